// ---- design/bit_sync.sv ----
/*
   Two flip-flop synchroniser for a bundle of independent level inputs.
   Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module bit_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,        // System clock.
   input wire logic rst,            // Synchronous reset, active high.
   input wire logic [W-1:0] d,      // Asynchronous levels.
   output logic [W-1:0] q           // Synchronised levels.
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } sync_state_t;

   sync_state_t s_r;
   sync_state_t s_nxt;

   if (W < 1) begin : g_chk
      $error("bit_sync needs W of at least 1.");
   end

   always_comb begin
      s_nxt.meta = d;
      s_nxt.sync = s_r.meta;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.sync;
endmodule : bit_sync

// ---- design/synth_ctrl.sv ----
/*
   Controller end: an AHB-Lite register slave that takes a frequency in kHz,
   computes the divider words, shifts the 32-bit frame out on the serial
   link, pulses enable, and then checks the lock flag.
   Assumes one AHB-Lite master, single word transfers, and the synthesizer
   end sampling the link through two flip-flops.
*/
// The register offsets and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
// Function
// R1: Drive select pattern 110 before loading.
// R2: Frame order reference, main, swallow, MSB first.
// R3: Controller appends trailing high control bit.
// R4: Device latches only when control bit set.
// R5: Reference divider is 2560 for 5 kHz.
// R6: Main divider is frequency over 320.
// R7: Swallow is frequency/5 minus 64 times main.
// R8: Relay key held low for lock.
// R9: Locked drives flag high, indicator off.
// R10: Check lock flag after each frame.
// R11: Data on clock rise, enable latches.
// R12: Enable clears fault; unlock sets it.
// R13: Thirty-two clocks, then enable pulse.
module synth_ctrl
   import synth_loader_pkg::*;
#(
   parameter int HALF_CYC = SER_HALF_CYC,
   parameter int LOCK_CYC = LOCK_CHECK_CYC
) (
   input wire logic ref_clk,             // System clock, 20 MHz.
   input wire logic rst,                 // Synchronous reset, active high.
   input wire logic hsel,                // AHB slave select.
   input wire logic [ADDR_W-1:0] haddr,  // AHB byte address.
   input wire logic [1:0] htrans,        // AHB transfer type.
   input wire logic hwrite,              // AHB write when high.
   input wire logic [2:0] hsize,         // AHB size, word only.
   input wire logic [31:0] hwdata,       // AHB write data.
   input wire logic hready,              // AHB bus ready.
   output logic [31:0] hrdata,           // AHB read data.
   output logic hreadyout,               // AHB slave ready.
   output logic hresp,                   // AHB response, always OKAY.
   output logic irq,                     // Interrupt, high while unmasked status set.
   synth_link_if.ctrl link               // Serial link to the synthesizer.
);
   typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_ENA, ST_CHECK} ctrl_st_t;

   typedef struct packed {
      logic [2:0] sel;
      logic sclk;
      logic sdata;
      logic sena;
      logic key;
      logic [FREQ_W-1:0] freq;
      logic [FRAME_W-1:0] frame;
      logic [5:0] bit_idx;
      logic [TIMER_W-1:0] timer;
      ctrl_st_t st;
      logic valid;
      logic flag_d;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
      logic dph_wr;
      logic [ADDR_W-1:0] dph_addr;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } ctrl_state_t;

   localparam logic [TIMER_W-1:0] HALF_LAST = TIMER_W'(HALF_CYC - 1);
   localparam logic [TIMER_W-1:0] LOCK_LAST = TIMER_W'(LOCK_CYC - 1);
   localparam logic [5:0] LAST_BIT = 6'(FRAME_W - 1);

   ctrl_state_t s_r;
   ctrl_state_t s_nxt;
   logic flag_s;

   if (HALF_CYC < 3 || LOCK_CYC < 1 || LOCK_CYC >= (1 << TIMER_W)) begin : g_chk
      $error("synth_ctrl timing parameters out of range.");
   end

   // ----------------------------------------------------------------
   // Frame builder
   // ----------------------------------------------------------------
   function automatic logic [FRAME_W-1:0] frame_word(input logic [FREQ_W-1:0] f);
      logic [FREQ_W-1:0] nq;
      logic [FREQ_W-1:0] aq;
      nq = f / N_DIVISOR;                                                 // [R6]
      aq = (f / A_DIVISOR) - (A_SCALE * nq);                              // [R7]
      return {REF_DIV_5K, nq[N_W-1:0], aq[A_W-1:0], 1'b1};                // [R2] [R3] [R5]
   endfunction : frame_word

   bit_sync #(.W(1)) u_flag_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d(link.fault_flag),
      .q(flag_s)
   );

   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic go;
      ev = '0;
      go = 1'b0;
      s_nxt = s_r;
      s_nxt.flag_d = flag_s;
      s_nxt.sel = SEL_PATTERN;                                            // [R1]
      s_nxt.ready = 1'b1;
      s_nxt.resp = HRESP_OKAY;
      // ----------------------------------------------------------------
      // Bus data phase: writes
      // ----------------------------------------------------------------
      s_nxt.dph_wr = 1'b0;
      if (s_r.dph_wr) begin
         unique case (s_r.dph_addr)
            OFS_CTRL: begin
               s_nxt.key = hwdata[CTRL_KEY];                              // [R8]
               go = hwdata[CTRL_GO];
            end
            OFS_FREQ: s_nxt.freq = hwdata[FREQ_W-1:0];
            OFS_IRQ_MASK: s_nxt.irq_mask = hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // ----------------------------------------------------------------
      // Bus address phase: decode, read data, read-to-clear
      // ----------------------------------------------------------------
      if (hsel && hready && htrans == HTRANS_NONSEQ) begin
         s_nxt.dph_wr = hwrite;
         s_nxt.dph_addr = haddr;
         s_nxt.rdata = '0;
         if (!hwrite) begin
            unique case (haddr)
               OFS_CTRL: s_nxt.rdata[CTRL_KEY] = s_r.key;
               OFS_FREQ: s_nxt.rdata[FREQ_W-1:0] = s_r.freq;
               OFS_STATUS: begin
                  s_nxt.rdata[STATUS_BUSY] = (s_r.st != ST_IDLE);
                  s_nxt.rdata[STATUS_FLAG] = flag_s;
                  s_nxt.rdata[STATUS_VALID] = s_r.valid;
               end
               OFS_IRQ_STAT: begin
                  s_nxt.rdata[IRQ_W-1:0] = s_r.irq_stat;
                  s_nxt.irq_stat = '0;
               end
               OFS_IRQ_MASK: s_nxt.rdata[IRQ_W-1:0] = s_r.irq_mask;
               default: ;
            endcase
         end
      end
      // ----------------------------------------------------------------
      // Serial sequencer
      // ----------------------------------------------------------------
      if (s_r.timer != '0) begin
         s_nxt.timer = s_r.timer - 1'b1;
      end
      unique case (s_r.st)
         ST_IDLE: begin
            if (s_r.valid && s_r.flag_d && !flag_s) begin
               s_nxt.valid = 1'b0;
               ev[IRQ_FAULT] = 1'b1;
            end
            if (go) begin
               s_nxt.frame = frame_word(s_r.freq);
               s_nxt.sdata = s_nxt.frame[FRAME_W-1];                      // [R2]
               s_nxt.sclk = 1'b0;
               s_nxt.bit_idx = '0;
               s_nxt.timer = HALF_LAST;
               s_nxt.valid = 1'b0;
               s_nxt.st = ST_LOW;
            end
         end
         ST_LOW: begin
            if (s_r.timer == '0) begin
               s_nxt.sclk = 1'b1;                                         // [R11]
               s_nxt.timer = HALF_LAST;
               s_nxt.st = ST_HIGH;
            end
         end
         ST_HIGH: begin
            if (s_r.timer == '0) begin
               s_nxt.sclk = 1'b0;
               s_nxt.timer = HALF_LAST;
               if (s_r.bit_idx == LAST_BIT) begin
                  s_nxt.sena = 1'b1;                                      // [R13]
                  s_nxt.st = ST_ENA;
               end else begin
                  s_nxt.bit_idx = s_r.bit_idx + 1'b1;
                  s_nxt.frame = {s_r.frame[FRAME_W-2:0], 1'b0};
                  s_nxt.sdata = s_r.frame[FRAME_W-2];
                  s_nxt.st = ST_LOW;
               end
            end
         end
         ST_ENA: begin
            if (s_r.timer == '0) begin
               s_nxt.sena = 1'b0;                                         // [R11]
               s_nxt.timer = LOCK_LAST;
               ev[IRQ_DONE] = 1'b1;
               s_nxt.st = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (s_r.timer == '0) begin
               s_nxt.valid = flag_s;                                      // [R10]
               ev[IRQ_LOCK] = flag_s;
               ev[IRQ_FAULT] = !flag_s;
               s_nxt.st = ST_IDLE;
            end
         end
      endcase
      // New events win over a read-to-clear in the same cycle.
      s_nxt.irq_stat = s_nxt.irq_stat | ev;
      s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.sel <= SEL_PATTERN;
         s_r.st <= ST_IDLE;
         s_r.ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign hrdata = s_r.rdata;
   assign hreadyout = s_r.ready;
   assign hresp = s_r.resp;
   assign irq = s_r.irq;
   assign link.ser_clk = s_r.sclk;
   assign link.ser_data = s_r.sdata;
   assign link.ser_enable = s_r.sena;
   assign link.select_line_0 = s_r.sel[0];
   assign link.select_line_1 = s_r.sel[1];
   assign link.select_line_2 = s_r.sel[2];
   assign link.antenna_relay_key = s_r.key;
endmodule : synth_ctrl

// ---- design/synth_link_if.sv ----
/*
   Pin bundle between the station controller and the synthesizer loader.
   Assumes both ends sit on the same board wiring; no clock belongs to it.
*/
`timescale 1ns/1ps
interface synth_link_if;
   logic ser_clk;
   logic ser_data;
   logic ser_enable;
   logic select_line_0;
   logic select_line_1;
   logic select_line_2;
   logic antenna_relay_key;
   logic fault_flag;

   modport ctrl (
      output ser_clk, ser_data, ser_enable,
      output select_line_0, select_line_1, select_line_2, antenna_relay_key,
      input fault_flag
   );
   modport synth (
      input ser_clk, ser_data, ser_enable,
      input select_line_0, select_line_1, select_line_2, antenna_relay_key,
      output fault_flag
   );
endinterface : synth_link_if

// ---- design/synth_loader.sv ----
/*
   Synthesizer end: select decode, 32-bit serial shift register, divider
   latches, and the out-of-lock fault latch with its flag and indicator.
   Assumes all link pins are asynchronous to ref_clk and each serial level
   lasts at least three clock cycles.
*/
`timescale 1ns/1ps
module synth_loader
   import synth_loader_pkg::*;
(
   input wire logic ref_clk,             // System clock, 20 MHz.
   input wire logic rst,                 // Synchronous reset, active high.
   synth_link_if.synth link,             // Serial link from the controller.
   input wire logic lock_detect,         // Loop lock detector, high when locked.
   output logic [R_W-1:0] ref_div,       // Latched reference divider.
   output logic [N_W-1:0] main_div,      // Latched main divider.
   output logic [A_W-1:0] swallow_div,   // Latched swallow divider.
   output logic words_valid,             // Dividers have been latched once.
   output logic vco_enable,              // Oscillator on.
   output logic lock_led                 // Front indicator, on when out of lock.
);
   typedef struct packed {
      logic sclk_d;
      logic ena_d;
      logic [FRAME_W-1:0] shift;
      logic [R_W-1:0] rdiv;
      logic [N_W-1:0] ndiv;
      logic [A_W-1:0] adiv;
      logic loaded;
      logic fault;
      logic flag;
      logic led;
      logic vco;
   } dev_state_t;

   dev_state_t s_r;
   dev_state_t s_nxt;
   logic [7:0] pins_s;
   logic sclk_s;
   logic sdata_s;
   logic sena_s;
   logic [2:0] sel_s;
   logic key_s;
   logic lock_s;

   bit_sync #(.W(8)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .d({link.ser_clk, link.ser_data, link.ser_enable, link.select_line_2,
          link.select_line_1, link.select_line_0, link.antenna_relay_key, lock_detect}),
      .q(pins_s)
   );

   assign {sclk_s, sdata_s, sena_s, sel_s, key_s, lock_s} = pins_s;

   always_comb begin
      logic selected;
      logic locked;
      selected = 1'b0;
      locked = 1'b0;
      s_nxt = s_r;
      s_nxt.sclk_d = sclk_s;
      s_nxt.ena_d = sena_s;
      selected = (sel_s == SEL_PATTERN);                                  // [R1]
      // ----------------------------------------------------------------
      // Shift and latch
      // ----------------------------------------------------------------
      if (selected && sclk_s && !s_r.sclk_d) begin
         s_nxt.shift = {s_r.shift[FRAME_W-2:0], sdata_s};                 // [R11] [R13]
      end
      if (selected && sena_s && !s_r.ena_d) begin
         if (s_r.shift[CTRL_BIT]) begin                                   // [R4]
            s_nxt.rdiv = s_r.shift[R_LSB +: R_W];                         // [R2]
            s_nxt.ndiv = s_r.shift[N_LSB +: N_W];
            s_nxt.adiv = s_r.shift[A_LSB +: A_W];
            s_nxt.loaded = 1'b1;
         end
         s_nxt.fault = 1'b0;                                              // [R12]
      end
      // ----------------------------------------------------------------
      // Fault latch: a loss of lock after the clear wins over the clear.
      // ----------------------------------------------------------------
      locked = lock_s && !key_s;                                          // [R8]
      if (!locked) begin
         s_nxt.fault = 1'b1;                                              // [R12]
      end
      s_nxt.vco = !key_s;                                                 // [R8]
      s_nxt.flag = !s_nxt.fault;                                          // [R9]
      s_nxt.led = s_nxt.fault;                                            // [R9]
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.fault <= 1'b1;
         s_r.led <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.fault_flag = s_r.flag;
   assign ref_div = s_r.rdiv;
   assign main_div = s_r.ndiv;
   assign swallow_div = s_r.adiv;
   assign words_valid = s_r.loaded;
   assign vco_enable = s_r.vco;
   assign lock_led = s_r.led;
endmodule : synth_loader

// ---- design/synth_loader_pkg.sv ----
/*
   Shared constants for the synthesizer divider serial loader: frame layout,
   select pattern, serial timing, and the controller's register map.
   Assumes a single 20 MHz system clock on both ends.
*/
package synth_loader_pkg;
   // ----------------------------------------------------------------
   // Frame layout
   // ----------------------------------------------------------------
   localparam int R_W = 14;
   localparam int N_W = 10;
   localparam int A_W = 7;
   localparam int FRAME_W = R_W + N_W + A_W + 1;
   localparam int R_LSB = N_W + A_W + 1;
   localparam int N_LSB = A_W + 1;
   localparam int A_LSB = 1;
   localparam int CTRL_BIT = 0;
   localparam logic [2:0] SEL_PATTERN = 3'h3;
   localparam logic [R_W-1:0] REF_DIV_5K = 14'h0A00;
   // ----------------------------------------------------------------
   // Divider arithmetic
   // ----------------------------------------------------------------
   localparam int FREQ_W = 20;
   localparam logic [FREQ_W-1:0] N_DIVISOR = 20'h00140;
   localparam logic [FREQ_W-1:0] A_DIVISOR = 20'h00005;
   localparam logic [FREQ_W-1:0] A_SCALE = 20'h00040;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int SER_HALF_NS = 250;
   localparam int SER_HALF_CYC = (SER_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int LOCK_CHECK_US = 100;
   localparam int LOCK_CHECK_CYC = LOCK_CHECK_US * CLK_MHZ;
   localparam int TIMER_W = 16;
   // ----------------------------------------------------------------
   // Controller register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FREQ = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_KEY = 1;
   localparam int STATUS_BUSY = 0;
   localparam int STATUS_FLAG = 1;
   localparam int STATUS_VALID = 2;
   localparam int IRQ_W = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_LOCK = 1;
   localparam int IRQ_FAULT = 2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage : synth_loader_pkg

// ---- sim/synth_link_assertions.sv ----
/*
   Concurrent checks on the serial link between the controller and the loader.
   Assumes every link signal is sampled on ref_clk and rst is synchronous.
*/
`timescale 1ns/1ps
module synth_link_assertions
   import synth_loader_pkg::*;
(
   input wire logic ref_clk,            // System clock.
   input wire logic rst,                // Synchronous reset, active high.
   input wire logic ser_clk,            // Serial clock.
   input wire logic ser_data,           // Serial data.
   input wire logic ser_enable,         // Latch enable.
   input wire logic select_line_0,      // Select bit 0.
   input wire logic select_line_1,      // Select bit 1.
   input wire logic select_line_2,      // Select bit 2.
   input wire logic antenna_relay_key,  // Relay key.
   input wire logic fault_flag          // High while no fault is latched.
);
   // ----------------------------------------------------------------
   // Frame tracking
   // ----------------------------------------------------------------
   logic [5:0] rise_cnt_r;
   logic [31:0] frame_r;
   logic [3:0] idle_cnt_r;

   always_ff @(posedge ref_clk) begin
      if (rst || ser_enable) begin
         rise_cnt_r <= 6'h00;
         idle_cnt_r <= 4'h0;
      end else begin
         if ($rose(ser_clk)) begin
            rise_cnt_r <= rise_cnt_r + 6'h01;
         end
         if (idle_cnt_r != 4'hF) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if ($rose(ser_clk)) begin
         frame_r <= {frame_r[30:0], ser_data};
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_enable_pulse;
      ser_enable [*5] ##1 !ser_enable;
   endsequence
   sequence s_clock_high;
      ser_clk [*5] ##1 !ser_clk;
   endsequence

   a_select_code: assert property (select_line_0 && select_line_1 && !select_line_2)
      else $error("select code is not 110");
   a_frame_length: assert property ($rose(ser_enable) |-> rise_cnt_r == 6'h20)
      else $error("enable not after 32 clock rises");
   a_control_bit: assert property ($rose(ser_enable) |-> frame_r[CTRL_BIT])
      else $error("last frame bit is low");
   a_ref_field: assert property ($rose(ser_enable) |-> frame_r[31:R_LSB] == REF_DIV_5K)
      else $error("reference field wrong");
   a_clock_still: assert property (ser_enable |-> !ser_clk)
      else $error("clock high during enable");
   a_enable_width: assert property ($rose(ser_enable) |-> s_enable_pulse)
      else $error("enable pulse width wrong");
   a_clock_half: assert property ($rose(ser_clk) |-> s_clock_high)
      else $error("clock high phase wrong");
   a_data_steady: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
      else $error("data moved while clock high");
   a_key_drops_flag: assert property ($rose(antenna_relay_key) |-> ##[1:10] !fault_flag)
      else $error("flag stayed high with key raised");
   a_fault_sticks: assert property (!fault_flag && idle_cnt_r == 4'hF |=> !fault_flag)
      else $error("flag rose without enable");
endmodule : synth_link_assertions

// ---- sim/test_synth_divider_serial_loader.sv ----
/*
   Self-checking bench: controller and loader joined by the link, plus a
   second loader fed directly with frames the controller would never send.
   Assumes a 20 MHz clock, the default serial half period and a shortened lock-check count.
*/
`timescale 1ns/1ps
module test_synth_divider_serial_loader
   import synth_loader_pkg::*;
();
   logic ref_clk, rst, hsel, hwrite, lock_detect, hreadyout, hresp, irq;
   logic words_valid, words_valid2, vco_enable, lock_led;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [ADDR_W-1:0] haddr;
   logic [31:0] hwdata, hrdata, rd;
   logic [R_W-1:0] ref_div, ref_div2;
   logic [N_W-1:0] main_div, main_div2;
   logic [A_W-1:0] swallow_div, swallow_div2;
   int error_cnt = 0;
   int num_checks = 0;

   synth_link_if link();
   synth_link_if rlink();
   synth_ctrl #(.HALF_CYC(5), .LOCK_CYC(20)) synth_ctrl_inst (
      .ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .link(link)
   );
   synth_loader synth_loader_inst (
      .ref_clk, .rst, .link(link), .lock_detect, .ref_div, .main_div, .swallow_div,
      .words_valid, .vco_enable, .lock_led
   );
   synth_loader rogue_synth_loader_inst (
      .ref_clk, .rst, .link(rlink), .lock_detect(1'b1), .ref_div(ref_div2),
      .main_div(main_div2), .swallow_div(swallow_div2), .words_valid(words_valid2),
      .vco_enable(), .lock_led()
   );
   synth_link_assertions synth_link_assertions_inst (
      .ref_clk, .rst, .ser_clk(link.ser_clk), .ser_data(link.ser_data),
      .ser_enable(link.ser_enable), .select_line_0(link.select_line_0),
      .select_line_1(link.select_line_1), .select_line_2(link.select_line_2),
      .antenna_relay_key(link.antenna_relay_key), .fault_flag(link.fault_flag)
   );

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic guard(inout int n);
      @(posedge ref_clk);
      n++;
      if (n > 2000) begin
         error_cnt++;
         $display("MISMATCH at %0t: wait ran out", $time);
         end_sim();
      end
   endtask : guard

   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do guard(n); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do guard(n); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      ahb(1'b0, a, 32'h0);
      check(rd, exp, what);
      check(32'(hresp), 32'(HRESP_OKAY), "response code");
   endtask : rdchk

   // Shifts one frame on the rogue link, each clock level and the enable held five cycles, each data bit ten.
   task automatic send(input logic [31:0] fr, input logic [2:0] sel);
      {rlink.select_line_2, rlink.select_line_1, rlink.select_line_0} <= sel;
      for (int i = 31; i >= 0; i--) begin
         rlink.ser_data <= fr[i];
         repeat (5) @(posedge ref_clk);
         rlink.ser_clk <= 1'b1;
         repeat (5) @(posedge ref_clk);
         rlink.ser_clk <= 1'b0;
      end
      rlink.ser_enable <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rlink.ser_enable <= 1'b0;
      rlink.ser_data <= ~fr[0];
      repeat (10) @(posedge ref_clk);
   endtask : send

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check(32'({link.select_line_2, link.select_line_1, link.select_line_0}), 32'h3, "sel");
      check(32'(link.fault_flag), 32'h0, "flag at reset");
      check(32'(lock_led), 32'h1, "led at reset");
      check(32'(words_valid), 32'h0, "valid at reset");
      rdchk(8'h14, 32'h0, "unmapped read");
      rdchk(OFS_IRQ_MASK, 32'h0, "mask at reset");
   endtask : t_reset

   task automatic t_load(input logic [19:0] f, input logic [2:0] m);
      logic [19:0] n_exp;
      logic [19:0] a_exp;
      int n = 0;
      n_exp = f / 20'd320;
      a_exp = f / 20'd5 - 20'd64 * n_exp;
      ahb(1'b1, OFS_IRQ_MASK, 32'(m));
      ahb(1'b1, OFS_FREQ, 32'(f));
      ahb(1'b1, OFS_CTRL, 32'h1);
      rd = 32'h1;
      while (rd[STATUS_BUSY] !== 1'b0) begin
         guard(n);
         ahb(1'b0, OFS_STATUS, 32'h0);
      end
      check(rd, 32'h6, "status after load");
      check(32'(irq), 32'(|(m & 3'h3)), "irq after load");
      rdchk(OFS_IRQ_STAT, 32'h3, "events after load");
      check(32'(irq), 32'h0, "irq after clear");
      check(32'(ref_div), 32'h0A00, "ref divider");
      check(32'(main_div), 32'(n_exp[9:0]), "main divider");
      check(32'(swallow_div), 32'(a_exp[6:0]), "swallow divider");
      check(32'(words_valid), 32'h1, "latched");
      check(32'({link.fault_flag, lock_led, vco_enable}), 32'h5, "locked pins");
   endtask : t_load

   task automatic t_key();
      int n = 0;
      ahb(1'b1, OFS_CTRL, 32'h2);
      while (irq !== 1'b1) guard(n);
      check(32'({link.fault_flag, vco_enable}), 32'h0, "keyed pins");
      rdchk(OFS_IRQ_STAT, 32'h4, "fault on key");
      rdchk(OFS_CTRL, 32'h2, "key readback");
      ahb(1'b1, OFS_CTRL, 32'h0);
   endtask : t_key

   task automatic t_unlock();
      int n = 0;
      lock_detect <= 1'b0;
      while (irq !== 1'b1) guard(n);
      check(32'({link.fault_flag, lock_led}), 32'h1, "unlock pins");
      lock_detect <= 1'b1;
      repeat (20) @(posedge ref_clk);
      check(32'(link.fault_flag), 32'h0, "flag held low");
      rdchk(OFS_IRQ_STAT, 32'h4, "fault event");
      rdchk(OFS_STATUS, 32'h0, "status after fault");
   endtask : t_unlock

   task automatic t_rogue();
      send({14'h1234, 10'h2CD, 7'h5A, 1'b0}, 3'h3);
      check(32'(words_valid2), 32'h0, "control bit low");
      send({14'h1234, 10'h2CD, 7'h5A, 1'b1}, 3'h6);
      check(32'(words_valid2), 32'h0, "wrong select");
      send({14'h1234, 10'h2CD, 7'h5A, 1'b1}, 3'h3);
      check(32'(words_valid2), 32'h1, "good frame");
      check(32'({ref_div2, main_div2, swallow_div2}), 32'({14'h1234, 10'h2CD, 7'h5A}), "field order");
   endtask : t_rogue

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      lock_detect = 1'b1;
      {rlink.ser_clk, rlink.ser_data, rlink.ser_enable, rlink.antenna_relay_key} = 4'h0;
      {rlink.select_line_2, rlink.select_line_1, rlink.select_line_0} = 3'h0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_load(20'd300005, 3'h7);
      t_load(20'd100000, 3'h4);
      t_key();
      t_load(20'd300005, 3'h7);
      t_unlock();
      t_load(20'd100000, 3'h0);
      t_rogue();
      end_sim();
   end
endmodule : test_synth_divider_serial_loader
